/* File: design/waveform_engine.sv */
// programmable waveform engine with apb register access
// assumes pclk is the interface clock and pins are synchronous to it
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - sampling mode bit 6 picks synchronous or asynchronous wait sampling
// - synchronous mode captures wait inputs on one rising edge
// - asynchronous mode samples wait inputs over two rising edges
// - four program memories: single write, single read, fifo write, read
// - each program holds up to seven 32-bit intervals, I0 to I6
// - each interval sets strobes, data bus, wait use and address
// - every interval starts on a rising clock edge
// - branching to interval 7 ends the waveform, from any interval
// - idle control bit 7 reads 0 while busy, 1 when idle
// - idle data bus floats when bit 0 is 0, else holds last value
// - tristate mode off: idle strobes follow idle level bits 5..0
// - tristate mode on: bits 7..4 enables, 3..0 values, strobes 4,5 off
// - tristate mode bit governs output byte of every loaded program
// - idle strobe driven high with config bit 1 becomes open drain
// - idle strobe with config bit 0 drives full cmos levels
// - four-byte descriptor typed as fixed or branch interval
// - fixed interval lasts its length byte in cycles, 0 meaning 256
// - branch interval combines two inputs by and, or, xor and branches
module waveform_engine #(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 6,
  parameter int READY_W = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // wait inputs
  input wire logic [READY_W-1:0] ready_in,
  // strobe outputs
  output logic [5:0] strobe_outputs,
  output logic [5:0] strobe_oe,
  // data bus, low_data_lane in 7..0, high_data_lane in 15..8
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  // address bus
  output logic [ADDR_W-1:0] addr_out
);
  import wave_engine_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // flat memory word of an interval
  function automatic logic [4:0] mem_index(input logic [1:0] wave,
                                           input logic [2:0] step);
    logic [4:0] base;
    base = 5'(wave) * 5'(NUM_INTERVALS);
    mem_index = 5'(base + 5'(step));
  endfunction

  // strobe value and enable from an output byte
  function automatic logic [11:0] strobe_map(input logic [7:0] levels,
                                             input logic tri_mode,
                                             input logic [5:0] cfg);
    logic [5:0] val;
    logic [5:0] oe;
    val = '0;
    oe = '0;
    if (tri_mode) begin
      val[3:0] = levels[3:0];
      oe[3:0] = levels[OE_LSB+3:OE_LSB];
    end else begin
      val = levels[5:0];
      oe = '1;
    end
    for (int i = 0; i < 6; i++) begin
      if (val[i] && cfg[i]) begin
        oe[i] = 1'b0;
      end
    end
    strobe_map = {oe, val};
  endfunction

  // one input term of a branch interval
  function automatic logic term_value(input logic [2:0] sel,
                                      input logic [5:0] rdy,
                                      input logic internal_ready);
    if (sel < 3'h6) begin
      term_value = rdy[sel];
    end else begin
      term_value = internal_ready;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  engine_state_e state_reg;
  engine_state_e state_next;
  logic [2:0] idx_reg;
  logic [2:0] idx_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [1:0] wave_reg;
  logic [1:0] wave_next;
  logic idle_drive_reg;
  logic [7:0] idle_pins_reg;
  logic sync_sel_reg;
  logic int_ready_reg;
  logic [7:0] out_cfg_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [31:0] wave_mem [MEM_WORDS];
  logic [READY_W-1:0] rdy_cap_reg;
  logic [READY_W-1:0] rdy_meta_reg;
  logic [READY_W-1:0] rdy_sync_reg;

  logic apb_write;
  logic wave_hit;
  logic wave_slot_ok;
  logic [4:0] wave_word;
  logic start;
  logic abort;
  logic [31:0] desc;
  logic [31:0] desc_n;
  logic [5:0] rdy_use;
  logic branch_result;
  logic term_a;
  logic term_b;
  logic is_write_wave;
  logic is_write_wave_n;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign apb_write = psel && penable && pwrite && pready;
  assign wave_hit = (paddr & ADDR_WAVE_MASK) == ADDR_WAVE_BASE;
  assign wave_slot_ok = wave_hit && (paddr[4:2] != IDLE_INDEX);
  assign wave_word = mem_index(paddr[6:5], paddr[4:2]);
  assign start = apb_write && (paddr == ADDR_TRIGGER) &&
                 !pwdata[ABORT_BIT] && (state_reg == ST_IDLE);
  assign abort = apb_write && (paddr == ADDR_TRIGGER) && pwdata[ABORT_BIT];

  // ready comes one edge after setup: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= '0;
        if (wave_hit && !wave_slot_ok) begin
          prdata <= '0;
        end else if (wave_hit) begin
          prdata <= wave_mem[wave_word];
        end else begin
          case (paddr)
            ADDR_IDLE_STATUS: begin
              prdata[DONE_BIT] <= (state_reg == ST_IDLE);
              prdata[IDLE_DRIVE_BIT] <= idle_drive_reg;
            end
            ADDR_IDLE_PINS: prdata[7:0] <= idle_pins_reg;
            ADDR_SAMPLE_MODE: begin
              prdata[SYNC_SEL_BIT] <= sync_sel_reg;
              prdata[INT_READY_BIT] <= int_ready_reg;
            end
            ADDR_OUT_CFG: prdata[7:0] <= out_cfg_reg;
            ADDR_TRIGGER: prdata[1:0] <= wave_reg;
            ADDR_WRITE_DATA: prdata[DATA_W-1:0] <= wdata_reg;
            ADDR_READ_DATA: prdata[DATA_W-1:0] <= rdata_reg;
            ADDR_ADDRESS: prdata[ADDR_W-1:0] <= addr_out;
            default: pslverr <= 1'b1;
          endcase
        end
      end
    end
  end

  // software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_drive_reg <= 1'b0;
      idle_pins_reg <= IDLE_PINS_RESET;
      sync_sel_reg <= 1'b0;
      int_ready_reg <= 1'b0;
      out_cfg_reg <= OUT_CFG_RESET;
      wdata_reg <= '0;
    end else if (apb_write) begin
      case (paddr)
        ADDR_IDLE_STATUS: idle_drive_reg <= pwdata[IDLE_DRIVE_BIT];
        ADDR_IDLE_PINS: idle_pins_reg <= pwdata[7:0];
        ADDR_SAMPLE_MODE: begin
          sync_sel_reg <= pwdata[SYNC_SEL_BIT];
          int_ready_reg <= pwdata[INT_READY_BIT];
        end
        ADDR_OUT_CFG: out_cfg_reg <= pwdata[7:0];
        ADDR_WRITE_DATA: wdata_reg <= pwdata[DATA_W-1:0];
        default: ;
      endcase
    end
  end

  // waveform program memories, slot 7 of each is the idle state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        wave_mem[i] <= '0;
      end
    end else if (apb_write && wave_slot_ok) begin
      wave_mem[wave_word] <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wait input sampling

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_cap_reg <= '0;
      rdy_meta_reg <= '0;
      rdy_sync_reg <= '0;
    end else begin
      rdy_cap_reg <= ready_in;
      rdy_meta_reg <= ready_in;
      rdy_sync_reg <= rdy_meta_reg;
    end
  end

  assign rdy_use = sync_sel_reg ? 6'(rdy_cap_reg) : 6'(rdy_sync_reg);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  assign desc = wave_mem[mem_index(wave_reg, idx_reg)];
  assign term_a = term_value(desc[LOGIC_LSB+TERMA_LSB +: 3], rdy_use,
                             int_ready_reg);
  assign term_b = term_value(desc[LOGIC_LSB+TERMB_LSB +: 3], rdy_use,
                             int_ready_reg);

  always_comb begin
    case (desc[LOGIC_LSB+LFUNC_LSB +: 2])
      LF_OR: branch_result = term_a | term_b;
      LF_XOR: branch_result = term_a ^ term_b;
      default: branch_result = term_a & term_b;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    wave_next = wave_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_RUN;
          idx_next = FIRST_INDEX;
          cnt_next = '0;
          wave_next = pwdata[1:0];
        end
      end
      ST_RUN: begin
        if (abort) begin
          state_next = ST_IDLE;
          idx_next = IDLE_INDEX;
        end else if (desc[OPC_LSB+OPC_BRANCH]) begin
          cnt_next = '0;
          idx_next = branch_result ? desc[LEN_LSB+BR1_LSB +: 3]
                                   : desc[LEN_LSB+BR0_LSB +: 3];
        end else if (cnt_reg == 8'(desc[LEN_LSB +: 8] - 8'h01)) begin
          cnt_next = '0;
          idx_next = 3'(idx_reg + 3'h1);
        end else begin
          cnt_next = 8'(cnt_reg + 8'h01);
        end
        if (idx_next == IDLE_INDEX) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
        idx_next = IDLE_INDEX;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      idx_reg <= IDLE_INDEX;
      cnt_reg <= '0;
      wave_reg <= WAVE_SINGLE_WRITE;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      wave_reg <= wave_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin outputs, loaded with the interval that starts at this edge

  assign desc_n = wave_mem[mem_index(wave_next, idx_next)];
  assign is_write_wave = (wave_reg == WAVE_SINGLE_WRITE) ||
                         (wave_reg == WAVE_FIFO_WRITE);
  assign is_write_wave_n = (wave_next == WAVE_SINGLE_WRITE) ||
                           (wave_next == WAVE_FIFO_WRITE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_outputs <= '0;
      strobe_oe <= '0;
    end else if (state_next == ST_IDLE) begin
      {strobe_oe, strobe_outputs} <=
        strobe_map(idle_pins_reg, out_cfg_reg[TRISTATE_MODE_BIT],
                   out_cfg_reg[5:0]);
    end else begin
      {strobe_oe, strobe_outputs} <=
        strobe_map(desc_n[OUT_LSB +: 8], out_cfg_reg[TRISTATE_MODE_BIT],
                   out_cfg_reg[5:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else if (state_next == ST_IDLE) begin
      data_oe <= idle_drive_reg;
    end else if (is_write_wave_n && desc_n[OPC_LSB+OPC_DATA]) begin
      data_out <= wdata_reg;
      data_oe <= 1'b1;
    end else begin
      data_oe <= 1'b0;
    end
  end

  // read capture while a read interval has its data bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= '0;
    end else if (state_reg == ST_RUN && !is_write_wave &&
                 desc[OPC_LSB+OPC_DATA]) begin
      rdata_reg <= data_in;
    end
  end

  // address: software load, or step at the start of an incrementing interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_out <= '0;
    end else if (apb_write && paddr == ADDR_ADDRESS) begin
      addr_out <= pwdata[ADDR_W-1:0];
    end else if (state_next == ST_RUN && desc_n[OPC_LSB+OPC_INCAD] &&
                 (start || idx_next != idx_reg)) begin
      addr_out <= ADDR_W'(addr_out + 1'b1);
    end
  end

endmodule

/* File: inc/wave_engine_pkg.sv */
// waveform engine shared constants: register map, field layout, states
// assumes a 32-bit apb slave with 12-bit byte addresses
package wave_engine_pkg;

  // apb byte addresses
  localparam logic [11:0] ADDR_IDLE_STATUS = 12'h000;
  localparam logic [11:0] ADDR_IDLE_PINS = 12'h004;
  localparam logic [11:0] ADDR_SAMPLE_MODE = 12'h008;
  localparam logic [11:0] ADDR_OUT_CFG = 12'h00C;
  localparam logic [11:0] ADDR_TRIGGER = 12'h010;
  localparam logic [11:0] ADDR_WRITE_DATA = 12'h014;
  localparam logic [11:0] ADDR_READ_DATA = 12'h018;
  localparam logic [11:0] ADDR_ADDRESS = 12'h01C;
  localparam logic [11:0] ADDR_WAVE_BASE = 12'h100;
  localparam logic [11:0] ADDR_WAVE_MASK = 12'hF80;

  // register bit positions
  localparam int DONE_BIT = 7;
  localparam int IDLE_DRIVE_BIT = 0;
  localparam int SYNC_SEL_BIT = 6;
  localparam int INT_READY_BIT = 5;
  localparam int TRISTATE_MODE_BIT = 7;
  localparam int ABORT_BIT = 7;
  localparam int OE_LSB = 4;

  // waveform memory layout
  localparam int NUM_WAVES = 4;
  localparam int NUM_INTERVALS = 7;
  localparam int MEM_WORDS = NUM_WAVES * NUM_INTERVALS;
  localparam logic [2:0] IDLE_INDEX = 3'h7;
  localparam logic [2:0] FIRST_INDEX = 3'h0;

  // waveform types
  localparam logic [1:0] WAVE_SINGLE_WRITE = 2'h0;
  localparam logic [1:0] WAVE_SINGLE_READ = 2'h1;
  localparam logic [1:0] WAVE_FIFO_WRITE = 2'h2;
  localparam logic [1:0] WAVE_FIFO_READ = 2'h3;

  // descriptor bytes and fields
  localparam int LEN_LSB = 0;
  localparam int OPC_LSB = 8;
  localparam int LOGIC_LSB = 16;
  localparam int OUT_LSB = 24;
  localparam int OPC_BRANCH = 0;
  localparam int OPC_DATA = 1;
  localparam int OPC_INCAD = 3;
  localparam int BR0_LSB = 0;
  localparam int BR1_LSB = 3;
  localparam int TERMB_LSB = 0;
  localparam int TERMA_LSB = 3;
  localparam int LFUNC_LSB = 6;

  // logic functions of a branch interval
  localparam logic [1:0] LF_AND = 2'h0;
  localparam logic [1:0] LF_OR = 2'h1;
  localparam logic [1:0] LF_XOR = 2'h2;

  // reset values
  localparam logic [7:0] IDLE_PINS_RESET = 8'h00;
  localparam logic [7:0] OUT_CFG_RESET = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } engine_state_e;

endpackage

/* File: testbench/programmable_waveform_idle_control_test.sv */
// testbench: apb register tests and waveform runs against a peripheral
// assumes waveform_engine, wave_peripheral and the bound checker
`timescale 1ns/10ps
module programmable_waveform_idle_control_test;
  import wave_engine_pkg::*;
  localparam logic [5:0] WR_OUT [8] = '{6'h01, 6'h01, 6'h01, 6'h02,
    6'h02, 6'h03, 6'h30, 6'h30};
  localparam logic WR_OE [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
    1'b1, 1'b1};
  localparam logic [7:0] PINS [3] = '{8'h2A, 8'h2A, 8'h5F};
  localparam logic [7:0] CFG [3] = '{8'h00, 8'h0F, 8'h80};
  localparam logic [5:0] OE [3] = '{6'h3F, 6'h35, 6'h05};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] rdy_cmd = 6'h00;
  logic [5:0] ready_in;
  logic [5:0] strobe_outputs;
  logic [5:0] strobe_oe;
  logic [15:0] data_in;
  logic [15:0] data_out;
  logic data_oe;
  logic [5:0] addr_out;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  int lat [2];
  always #50 pclk = ~pclk;
  waveform_engine DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ready_in, .strobe_outputs,
    .strobe_oe, .data_in, .data_out, .data_oe, .addr_out);
  wave_peripheral peer (.data_out, .data_oe, .rdy_cmd, .ready_in, .data_in);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic load(logic [1:0] w, logic [31:0] i0, i1, i2);
    wr(12'(ADDR_WAVE_BASE + w * 32), i0);
    wr(12'(ADDR_WAVE_BASE + w * 32 + 4), i1);
    wr(12'(ADDR_WAVE_BASE + w * 32 + 8), i2);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdr(ADDR_IDLE_STATUS);
    check("done", 32'(rd[DONE_BIT]), 32'h1);
    rdr(ADDR_IDLE_PINS);
    check("pins", rd, {24'h0, IDLE_PINS_RESET});
    check("strobe oe", 32'(strobe_oe), 32'h3F);
    check("bus oe", 32'(data_oe), 32'h0);
    rdr(12'h020);
    check("error", 32'(err), 32'h1);
    $display("test reset done");
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_IDLE_PINS, {24'h0, PINS[c]});
      wr(ADDR_OUT_CFG, {24'h0, CFG[c]});
      repeat (2) @(posedge pclk);
      #1;
      check("oe", 32'(strobe_oe), 32'(OE[c]));
      check("lvl", 32'(strobe_outputs & OE[c]),
        32'(PINS[c] & OE[c]));
    end
    $display("test idle strobes done");
    for (int k = 0; k < 56; k++) begin
      n = ADDR_WAVE_BASE + (k % 28) / 7 * 32 + (k % 7) * 4;
      apb(k < 28, 12'(n), {20'hA5C3E, 12'(n)});
      if (k >= 28) begin
        check("wave word", rd, {20'hA5C3E, 12'(n)});
      end
    end
    rdr(12'h17C);
    check("slot 7", rd, 32'h0);
    $display("test memories done");
    wr(ADDR_WRITE_DATA, 32'hBEEF);
    wr(ADDR_IDLE_STATUS, 32'h1);
    wr(ADDR_OUT_CFG, 32'h0);
    wr(ADDR_IDLE_PINS, 32'h30);
    load(WAVE_SINGLE_WRITE, 32'h01000003, 32'h02000202, 32'h0300013F);
    wr(ADDR_TRIGGER, {30'h0, WAVE_SINGLE_WRITE});
    for (int c = 0; c < 8; c++) begin
      #1;
      check("pin", 32'(strobe_outputs), 32'(WR_OUT[c]));
      check("bus oe", 32'(data_oe), 32'(WR_OE[c]));
      @(posedge pclk);
    end
    check("bus", 32'(data_out), 32'hBEEF);
    $display("test write waveform done");
    load(WAVE_SINGLE_READ, 32'h05000200, 32'h0000013F, 32'h0);
    wr(ADDR_TRIGGER, {30'h0, WAVE_SINGLE_READ});
    rdr(ADDR_IDLE_STATUS);
    check("busy", 32'(rd[DONE_BIT]), 32'h0);
    wr(ADDR_TRIGGER, 32'h80);
    rdr(ADDR_IDLE_STATUS);
    check("aborted", 32'(rd[DONE_BIT]), 32'h1);
    wr(ADDR_TRIGGER, {30'h0, WAVE_SINGLE_READ});
    n = 0;
    #1;
    while (strobe_outputs === 6'h05) begin
      @(posedge pclk);
      #1;
      n++;
    end
    check("length", n, 256);
    rdr(ADDR_READ_DATA);
    check("read data", 32'(rd[15:0]), 32'hC35A);
    wr(ADDR_OUT_CFG, 32'h80);
    load(WAVE_FIFO_READ, 32'hF5000200, 32'h0000013F, 32'h0);
    wr(ADDR_TRIGGER, {30'h0, WAVE_FIFO_READ});
    #1;
    check("tri oe", 32'(strobe_oe), 32'h0F);
    check("tri pin", 32'(strobe_outputs), 32'h05);
    check("read bus oe", 32'(data_oe), 32'h0);
    wr(ADDR_TRIGGER, 32'h80);
    wr(ADDR_OUT_CFG, 32'h0);
    $display("test read waveform done");
    load(WAVE_FIFO_WRITE, 32'h00000108, 32'h04000801, 32'h0400013F);
    wr(ADDR_ADDRESS, 32'h05);
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_SAMPLE_MODE, m ? 32'h40 : 32'h0);
      rdr(ADDR_SAMPLE_MODE);
      check("mode", 32'(rd[SYNC_SEL_BIT]), 32'(m[0]));
      rdy_cmd <= 6'h00;
      wr(ADDR_TRIGGER, {30'h0, WAVE_FIFO_WRITE});
      repeat (3) @(posedge pclk);
      rdy_cmd <= 6'h01;
      n = 0;
      do begin
        @(posedge pclk);
        #1;
        n++;
      end while (strobe_outputs !== 6'h04);
      lat[m] = n;
      repeat (6) @(posedge pclk);
    end
    check("sync lag", 32'(lat[1]), 32'h2);
    check("async lag", 32'(lat[0] - lat[1]), 32'h1);
    rdr(ADDR_ADDRESS);
    check("address", rd, 32'h07);
    check("addr pins", 32'(addr_out), 32'h07);
    $display("test wait sampling done");
    report_and_stop();
  end
endmodule

/* File: testbench/wave_engine_chk.sv */
// checker: apb handshake, register readback and strobe pin relations
// assumes binding into waveform_engine, sees only its ports
`timescale 1ns/10ps
module wave_engine_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // strobes
  input wire logic [5:0] strobe_outputs,
  input wire logic [5:0] strobe_oe
);
  import wave_engine_pkg::*;
  logic [7:0] cfg_reg;
  logic [7:0] pins_reg;
  logic wr;
  logic rd;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  // shadow copies of written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= OUT_CFG_RESET;
    end else if (wr && paddr == ADDR_OUT_CFG) begin
      cfg_reg <= pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_reg <= IDLE_PINS_RESET;
    end else if (wr && paddr == ADDR_IDLE_PINS) begin
      pins_reg <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  a_setup_ready: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside access");
  a_err_unmapped: assert property (psel && !penable && paddr >= 12'h020
    && paddr < ADDR_WAVE_BASE |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_pins_read: assert property (rd && paddr == ADDR_IDLE_PINS |->
    prdata[7:0] == pins_reg) else $error("idle pin levels readback");
  a_od_release: assert property ($stable(cfg_reg) |->
    (strobe_outputs & strobe_oe & cfg_reg[5:0]) == 6'h00)
    else $error("open drain strobe driven high");
  a_tri_upper: assert property ($stable(cfg_reg) &&
    cfg_reg[TRISTATE_MODE_BIT] |-> strobe_oe[5:4] == 2'b00)
    else $error("strobes 4 and 5 driven in tristate mode");
endmodule

bind waveform_engine wave_engine_chk chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .strobe_outputs,
  .strobe_oe);

/* File: testbench/wave_peripheral.sv */
// external peripheral model: wait lines and a data word on the bus
// assumes the bench commands wait levels synchronous to pclk
`timescale 1ns/10ps
module wave_peripheral #(
  parameter logic [15:0] PERI_WORD = 16'hC35A
) (
  // device side
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  // bench commands
  input wire logic [5:0] rdy_cmd,
  // toward the device
  output logic [5:0] ready_in,
  output logic [15:0] data_in
);
  ////////////////////////////////////////////////////////////////////////////
  // bus level resolved from both drivers
  assign data_in = data_oe ? data_out : PERI_WORD;
  assign ready_in = rdy_cmd;
endmodule
